// ### src/ombc_pkg.sv
// shared constants for operating mode selection and bus configuration
package ombc_pkg;
  localparam logic [2:0] OMBC_MODE_0 = 3'h0;
  localparam logic [2:0] OMBC_MODE_1 = 3'h1;
  localparam logic [2:0] OMBC_MODE_2 = 3'h2;
  localparam logic [2:0] OMBC_MODE_3 = 3'h3;
  localparam logic [2:0] OMBC_MODE_4 = 3'h4;
  localparam logic [2:0] OMBC_MODE_5 = 3'h5;
  localparam logic [2:0] OMBC_MODE_6 = 3'h6;
  localparam logic [2:0] OMBC_MODE_7 = 3'h7;
  localparam logic [2:0] OMBC_MODE_RESET = 3'h0;
  // bit of the mode-pin port data register that forces mode 5
  localparam int OMBC_SWITCH_BIT = 5;
  // mode bits sit in the top three bits of that data register
  localparam int OMBC_MODE_POS = 5;
  localparam logic [7:0] OMBC_RAM_LO = 8'h80;
  localparam logic [7:0] OMBC_VEC_HI = 8'hFE;
  localparam logic [7:0] OMBC_VEC_LO = 8'hFF;
  localparam logic [15:0] OMBC_IOS_BASE = 16'h0100;
  localparam logic [15:0] OMBC_IOS_LAST = 16'h01FF;
  localparam logic [15:0] OMBC_P3_DDR = 16'h0004;
  localparam logic [15:0] OMBC_P4_DDR = 16'h0005;
  localparam logic [15:0] OMBC_P3_DATA = 16'h0006;
  localparam logic [15:0] OMBC_P4_DATA = 16'h0007;
  localparam logic [15:0] OMBC_P3_CSR = 16'h000F;
  localparam logic [1:0] OMBC_VEC_EXT_CYCLES = 2'h2;
  typedef enum logic [2:0] {
    OMBC_ST_ADDR = 3'b001,
    OMBC_ST_TURN = 3'b010,
    OMBC_ST_DATA = 3'b100
  } ombc_phase_t;
endpackage

// ### src/ombc_mode_latch.sv
// mode latch: strap capture at reset release and one-way mode 4 to 5 switch
`timescale 1ns/1ns
module ombc_mode_latch
  import ombc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [2:0] strap_i,
  input wire logic switch_i,
  output logic [2:0] mode_o,
  output logic captured_o
);
  logic [2:0] mode_reg;
  logic [2:0] mode_next;
  logic captured_reg;
  logic captured_next;

  always_comb begin
    mode_next = mode_reg;
    captured_next = 1'b1;
    if (!captured_reg) begin
      // first edge after release is the reset rising edge
      mode_next = strap_i;
    end else if (switch_i && mode_reg == OMBC_MODE_4) begin
      mode_next = OMBC_MODE_5;
    end
    // otherwise hold until next reset
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_reg <= OMBC_MODE_RESET;
      captured_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      captured_reg <= captured_next;
    end
  end

  assign mode_o = mode_reg;
  assign captured_o = captured_reg;
endmodule

// ### src/ombc_top.sv
// operating mode selection and bus configuration top
// Overview of operation
// - strap pins captured into mode latch on reset rising edge.
// - mode number is binary of latched straps, high is one.
// - latched mode readable through the mode-pin port data register.
// - modes 4 and 7 make all ports parallel I/O, no bus.
// - mode 7 strobe a is input strobe, strobe b output strobe.
// - mode 4 RAM answers page offsets 80 to FF, ROM removed.
// - mode 4 reset vector fetched from page offsets FE and FF.
// - in mode 4 writing bit 5 switches to mode 5 at once.
// - mode 5 port 3 is data bus, port 4 defaults to input.
// - mode 5 set port-4 direction bits give address outputs A0-A7.
// - mode 5 io select decodes external range 0x100 to 0x1FF.
// - mode 5 strobe a is io select, strobe b read/write.
// - multiplexed modes: port 3 low address then data while E high.
// - multiplexed modes: strobe a address strobe, strobe b read/write.
// - modes 0 to 3 port 4 always drives A8-A15.
// - mode 6 port 4 inputs after reset, direction bits enable A8-A15.
// - multiplexed memory options: 3 none, 2 RAM, 1 and 6 both.
// - vectors external in modes 1 to 3, internal in 4 to 7.
// - mode 0 reset vector external for first two E cycles.
// - mode 0 connects internal data bus to external bus.
// - port 3 and 4 slots external in modes 0-3, 5, 6.
// - set direction bit makes line output, clear makes it input.
// - multiplexed modes float port 3 between address and data.
`timescale 1ns/1ns
module ombc_top
  import ombc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic E_STB_I,
  input wire logic [2:0] MODE_STRAP_I,
  input wire logic [15:0] CPU_ADDR_I,
  input wire logic CPU_RW_I,
  input wire logic CPU_VALID_I,
  input wire logic VEC_FETCH_I,
  input wire logic [7:0] CPU_WDATA_I,
  input wire logic P2_DATA_WR_I,
  input wire logic [4:0] P2_PIN_I,
  input wire logic [7:0] P3_DDR_I,
  input wire logic [7:0] P3_OUT_I,
  input wire logic [7:0] P3_PIN_I,
  input wire logic [7:0] P4_DDR_I,
  input wire logic [7:0] P4_OUT_I,
  input wire logic P3_IN_STB_I,
  input wire logic P3_OUT_STB_I,
  output logic [2:0] MODE_O,
  output logic [7:0] P2_DATA_RD_O,
  output logic SINGLE_CHIP_O,
  output logic NON_MUX_O,
  output logic MUX_O,
  output logic RAM_SEL_O,
  output logic ROM_SEL_O,
  output logic EXT_SEL_O,
  output logic VEC_EXT_O,
  output logic DBUS_LINK_O,
  output logic [7:0] P3_OUT_O,
  output logic [7:0] P3_OE_N_O,
  output logic [7:0] P3_RDATA_O,
  output logic [7:0] P4_OUT_O,
  output logic [7:0] P4_OE_N_O,
  output logic STB_A_OUT_O,
  output logic STB_A_OE_N_O,
  output logic STB_A_IN_O,
  output logic STB_B_OUT_O,
  output logic P3_OUT_STB_O
);
  logic [2:0] mode;
  logic captured;
  logic switch_req;
  logic sc_mode;
  logic non_multiplexed_bus_mode_mode;
  logic mux_mode;
  logic io_space_select;
  logic port_slot;
  logic ext_ports;
  logic ram_win;
  logic rom_on;
  logic ram_on;
  logic ram_sel;
  logic rom_sel;
  logic ext_sel;
  ombc_phase_t phase_reg;
  ombc_phase_t phase_next;
  logic [1:0] vec_cnt_reg;
  logic [1:0] vec_cnt_next;
  logic [7:0] p3_out_reg;
  logic [7:0] p3_out_next;
  logic [7:0] p3_oe_n_reg;
  logic [7:0] p3_oe_n_next;
  logic [7:0] p4_out_reg;
  logic [7:0] p4_out_next;
  logic [7:0] p4_oe_n_reg;
  logic [7:0] p4_oe_n_next;
  logic stb_a_reg;
  logic stb_a_next;
  logic stb_b_reg;
  logic stb_b_next;
  logic [7:0] p3_rdata_reg;
  logic [7:0] p3_rdata_next;

  // per-line output enable from direction bits, active low
  function automatic logic [7:0] dir_oe_n(input logic [7:0] ddr);
    dir_oe_n = ~ddr;
  endfunction

  function automatic logic is_mux(input logic [2:0] m);
    is_mux = (m == OMBC_MODE_0) || (m == OMBC_MODE_1) ||
             (m == OMBC_MODE_2) || (m == OMBC_MODE_3) ||
             (m == OMBC_MODE_6);
  endfunction

  assign switch_req = P2_DATA_WR_I && CPU_WDATA_I[OMBC_SWITCH_BIT];

  ombc_mode_latch u_latch (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .strap_i(MODE_STRAP_I),
    .switch_i(switch_req),
    .mode_o(mode),
    .captured_o(captured)
  );

  assign sc_mode = (mode == OMBC_MODE_4) || (mode == OMBC_MODE_7);
  assign non_multiplexed_bus_mode_mode = (mode == OMBC_MODE_5);
  assign mux_mode = is_mux(mode);
  assign io_space_select = (CPU_ADDR_I >= OMBC_IOS_BASE) &&
                           (CPU_ADDR_I <= OMBC_IOS_LAST);
  assign port_slot = (CPU_ADDR_I == OMBC_P3_DDR) ||
                     (CPU_ADDR_I == OMBC_P4_DDR) ||
                     (CPU_ADDR_I == OMBC_P3_DATA) ||
                     (CPU_ADDR_I == OMBC_P4_DATA) ||
                     (CPU_ADDR_I == OMBC_P3_CSR);
  // port register slots leave the chip in every bus mode
  assign ext_ports = port_slot && (mux_mode || non_multiplexed_bus_mode_mode);

  always_comb begin
    ram_on = 1'b1;
    rom_on = 1'b1;
    case (mode)
      OMBC_MODE_3: begin
        ram_on = 1'b0;
        rom_on = 1'b0;
      end
      OMBC_MODE_2: rom_on = 1'b0;
      OMBC_MODE_4: rom_on = 1'b0;
      default: begin
        ram_on = 1'b1;
        rom_on = 1'b1;
      end
    endcase
  end

  // mode 4 mirrors RAM into the upper half of every page
  assign ram_win = (mode == OMBC_MODE_4) ?
                   (CPU_ADDR_I[7:0] >= OMBC_RAM_LO) :
                   (CPU_ADDR_I[15:8] == 8'h00 &&
                    CPU_ADDR_I[7:0] >= OMBC_RAM_LO);

  // saturates at two so the vector never goes back outside
  always_comb begin
    vec_cnt_next = vec_cnt_reg;
    if (E_STB_I && vec_cnt_reg != OMBC_VEC_EXT_CYCLES && captured) begin
      vec_cnt_next = vec_cnt_reg + 2'h1;
    end
  end

  always_comb begin
    phase_next = phase_reg;
    if (E_STB_I) begin
      case (phase_reg)
        OMBC_ST_ADDR: phase_next = OMBC_ST_TURN;
        OMBC_ST_TURN: phase_next = OMBC_ST_DATA;
        OMBC_ST_DATA: phase_next = OMBC_ST_ADDR;
        default: phase_next = OMBC_ST_ADDR;
      endcase
    end
  end

  always_comb begin
    p3_out_next = P3_OUT_I;
    p3_oe_n_next = dir_oe_n(P3_DDR_I);
    p4_out_next = P4_OUT_I;
    p4_oe_n_next = dir_oe_n(P4_DDR_I);
    stb_a_next = 1'b1;
    stb_b_next = 1'b1;
    p3_rdata_next = p3_rdata_reg;
    // first cycle after release still sees the reset mode; keep pins idle
    if (!captured) begin
      p3_oe_n_next = 8'hFF;
      p4_oe_n_next = 8'hFF;
    end else if (mux_mode) begin
      case (phase_reg)
        OMBC_ST_ADDR: begin
          p3_out_next = CPU_ADDR_I[7:0];
          p3_oe_n_next = 8'h00;
          // strobe drops a cycle before release so the latch closes on
          // a driven address
          stb_a_next = !E_STB_I;
        end
        OMBC_ST_TURN: begin
          p3_oe_n_next = 8'hFF;
          stb_a_next = 1'b0;
        end
        OMBC_ST_DATA: begin
          p3_out_next = CPU_WDATA_I;
          p3_oe_n_next = (CPU_VALID_I && !CPU_RW_I) ? 8'h00 : 8'hFF;
          stb_a_next = 1'b0;
          p3_rdata_next = P3_PIN_I;
        end
        default: p3_oe_n_next = 8'hFF;
      endcase
      stb_b_next = CPU_RW_I;
      if (mode == OMBC_MODE_6) begin
        p4_out_next = CPU_ADDR_I[15:8];
        p4_oe_n_next = dir_oe_n(P4_DDR_I);
      end else begin
        p4_out_next = CPU_ADDR_I[15:8];
        p4_oe_n_next = 8'h00;
      end
    end else if (non_multiplexed_bus_mode_mode) begin
      p3_out_next = CPU_WDATA_I;
      p3_oe_n_next = (CPU_VALID_I && !CPU_RW_I) ? 8'h00 : 8'hFF;
      p3_rdata_next = P3_PIN_I;
      p4_out_next = CPU_ADDR_I[7:0];
      p4_oe_n_next = dir_oe_n(P4_DDR_I);
      stb_a_next = !(CPU_VALID_I && io_space_select);
      stb_b_next = CPU_RW_I;
    end else begin
      stb_b_next = P3_OUT_STB_I;
      p3_rdata_next = P3_PIN_I;
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      phase_reg <= OMBC_ST_ADDR;
      vec_cnt_reg <= 2'h0;
      p3_out_reg <= 8'h00;
      p3_oe_n_reg <= 8'hFF;
      p4_out_reg <= 8'h00;
      p4_oe_n_reg <= 8'hFF;
      stb_a_reg <= 1'b1;
      stb_b_reg <= 1'b1;
      p3_rdata_reg <= 8'h00;
    end else begin
      phase_reg <= phase_next;
      vec_cnt_reg <= vec_cnt_next;
      p3_out_reg <= p3_out_next;
      p3_oe_n_reg <= p3_oe_n_next;
      p4_out_reg <= p4_out_next;
      p4_oe_n_reg <= p4_oe_n_next;
      stb_a_reg <= stb_a_next;
      stb_b_reg <= stb_b_next;
      p3_rdata_reg <= p3_rdata_next;
    end
  end

  assign MODE_O = mode;
  assign P2_DATA_RD_O[7:OMBC_MODE_POS] = mode;
  assign P2_DATA_RD_O[OMBC_MODE_POS-1:0] = P2_PIN_I;
  assign SINGLE_CHIP_O = sc_mode;
  assign NON_MUX_O = non_multiplexed_bus_mode_mode;
  assign MUX_O = mux_mode;
  // mode 5 reaches outside only through the io window and port slots
  always_comb begin
    ram_sel = CPU_VALID_I && ram_on && ram_win && !ext_ports;
    rom_sel = CPU_VALID_I && rom_on && CPU_ADDR_I[15] &&
              !(ram_on && ram_win);
    ext_sel = 1'b0;
    if (CPU_VALID_I && non_multiplexed_bus_mode_mode) begin
      ext_sel = io_space_select || ext_ports;
    end else if (CPU_VALID_I && !sc_mode) begin
      ext_sel = !ram_sel && !rom_sel &&
                (CPU_ADDR_I[15:5] != 11'h000 || ext_ports);
    end
  end
  assign RAM_SEL_O = ram_sel;
  assign ROM_SEL_O = rom_sel;
  assign EXT_SEL_O = ext_sel;
  always_comb begin
    case (mode)
      OMBC_MODE_1, OMBC_MODE_2, OMBC_MODE_3: VEC_EXT_O = 1'b1;
      OMBC_MODE_0: VEC_EXT_O = VEC_FETCH_I &&
                     (vec_cnt_reg != OMBC_VEC_EXT_CYCLES);
      default: VEC_EXT_O = 1'b0;
    endcase
  end
  assign DBUS_LINK_O = (mode == OMBC_MODE_0);
  assign P3_OUT_O = p3_out_reg;
  assign P3_OE_N_O = p3_oe_n_reg;
  assign P3_RDATA_O = p3_rdata_reg;
  assign P4_OUT_O = p4_out_reg;
  assign P4_OE_N_O = p4_oe_n_reg;
  assign STB_A_OUT_O = stb_a_reg;
  assign STB_A_OE_N_O = sc_mode; // input in single-chip modes
  assign STB_A_IN_O = P3_IN_STB_I;
  assign STB_B_OUT_O = stb_b_reg;
  assign P3_OUT_STB_O = (mode == OMBC_MODE_7) && !stb_b_reg;
endmodule

// ### tb/ombc_ext_mem.sv
// expansion bus memory model driving the port 3 pins
`timescale 1ns/1ns
module ombc_ext_mem #(
  parameter logic [7:0] RD_BYTE = 8'h5A
) (
  input wire logic [7:0] oe_n_i,
  input wire logic rw_i,
  input wire logic ext_i,
  output logic [7:0] pin_o
);
  // answers only external reads once the device lets go of the lines;
  // otherwise the inverse shows, as port 3 has no pull-up
  assign pin_o = (ext_i && rw_i && oe_n_i == 8'hFF) ?
                 RD_BYTE : ~RD_BYTE;
endmodule

// ### tb/ombc_asserts.sv
// concurrent checks on the mode and bus configuration top
`timescale 1ns/1ns
module ombc_chk
  import ombc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic [2:0] MODE_O,
  input wire logic [4:0] P2_PIN_I,
  input wire logic [7:0] P2_DATA_RD_O,
  input wire logic SINGLE_CHIP_O,
  input wire logic NON_MUX_O,
  input wire logic MUX_O,
  input wire logic P2_DATA_WR_I,
  input wire logic [7:0] CPU_WDATA_I,
  input wire logic [15:0] CPU_ADDR_I,
  input wire logic CPU_VALID_I,
  input wire logic STB_A_OUT_O,
  input wire logic [7:0] P3_OE_N_O,
  input wire logic [7:0] P4_DDR_I,
  input wire logic [7:0] P4_OE_N_O
);
  logic [1:0] age_reg;
  logic [1:0] age_next;
  logic sw;
  assign sw = MODE_O == OMBC_MODE_4 && P2_DATA_WR_I &&
    CPU_WDATA_I[OMBC_SWITCH_BIT];
  // age skips the strap capture edge, where the mode legally moves
  always_comb begin
    age_next = (age_reg == 2'h2) ? age_reg : age_reg + 2'h1;
  end
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) age_reg <= 2'h0;
    else age_reg <= age_next;
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_addr_end;
    MUX_O ##0 $fell(STB_A_OUT_O);
  endsequence
  // address still driven as the strobe falls, released a cycle later
  sequence s_addr_release;
    P3_OE_N_O == 8'h00 ##1 P3_OE_N_O == 8'hFF;
  endsequence
  property p_turn;
    s_addr_end |-> s_addr_release;
  endproperty
  AST_READBACK: assert property (P2_DATA_RD_O == {MODE_O, P2_PIN_I})
    else $error("mode readback wrong");
  AST_SINGLE: assert property (
    SINGLE_CHIP_O == (MODE_O inside {3'h4, 3'h7}))
    else $error("single chip decode wrong");
  AST_NONMUX: assert property (NON_MUX_O == (MODE_O == OMBC_MODE_5))
    else $error("non-multiplexed decode wrong");
  AST_MUXDEC: assert property (
    MUX_O == (MODE_O inside {[3'h0:3'h3], 3'h6}))
    else $error("multiplexed decode wrong");
  AST_SWITCH: assert property (sw |=> MODE_O == OMBC_MODE_5)
    else $error("mode 4 to 5 switch missed");
  AST_HOLD: assert property (
    age_reg == 2'h2 && !sw |=> $stable(MODE_O))
    else $error("mode changed without cause");
  AST_IOS: assert property (NON_MUX_O && CPU_VALID_I |=> STB_A_OUT_O ==
    !($past(CPU_ADDR_I) inside {[OMBC_IOS_BASE:OMBC_IOS_LAST]}))
    else $error("io select decode wrong");
  AST_P4DIR: assert property (
    MODE_O inside {3'h5, 3'h6} && age_reg == 2'h2
    |=> P4_OE_N_O == ~$past(P4_DDR_I))
    else $error("port 4 direction wrong");
  AST_TURN: assert property (p_turn)
    else $error("port 3 driven in turnaround");
endmodule
bind ombc_top ombc_chk ombc_chk_i (.CLK_I, .ARST_N_I, .MODE_O, .P2_PIN_I,
  .P2_DATA_RD_O, .SINGLE_CHIP_O, .NON_MUX_O, .MUX_O, .P2_DATA_WR_I,
  .CPU_WDATA_I, .CPU_ADDR_I, .CPU_VALID_I, .STB_A_OUT_O, .P3_OE_N_O,
  .P4_DDR_I, .P4_OE_N_O);

// ### tb/tb.sv
// self-checking bench for the mode and bus configuration top
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb import ombc_pkg::*;;
  logic CLK_I = 1'b0, ARST_N_I = 1'b0, E_STB_I = 1'b0, CPU_RW_I = 1'b1;
  logic CPU_VALID_I = 1'b0, VEC_FETCH_I = 1'b1, P2_DATA_WR_I = 1'b0;
  logic P3_IN_STB_I = 1'b1, P3_OUT_STB_I = 1'b1;
  logic [2:0] MODE_STRAP_I = 3'h0;
  logic [15:0] CPU_ADDR_I = 16'h0000;
  logic [7:0] CPU_WDATA_I = 8'h00, P3_DDR_I = 8'h00, P3_OUT_I = 8'h00;
  logic [7:0] P4_DDR_I = 8'h00, P4_OUT_I = 8'h00;
  logic [4:0] P2_PIN_I = 5'h15;
  logic [2:0] MODE_O;
  logic [7:0] P3_PIN_I, P2_DATA_RD_O, P3_OUT_O, P3_OE_N_O, P3_RDATA_O;
  logic [7:0] P4_OUT_O, P4_OE_N_O;
  logic SINGLE_CHIP_O, NON_MUX_O, MUX_O, RAM_SEL_O, ROM_SEL_O, EXT_SEL_O;
  logic VEC_EXT_O, DBUS_LINK_O, STB_A_OUT_O, STB_A_OE_N_O, STB_A_IN_O;
  logic STB_B_OUT_O, P3_OUT_STB_O;
  int err_total = 0, check_count = 0, cyc = 0;
  ombc_top ombc_top_i (.*);
  ombc_ext_mem ombc_ext_mem_i (.oe_n_i(P3_OE_N_O), .rw_i(STB_B_OUT_O),
    .ext_i(EXT_SEL_O), .pin_o(P3_PIN_I));
  always #2 CLK_I = ~CLK_I;
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(negedge CLK_I);
  endtask
  // straps flipped after capture so a leaky latch shows up
  task automatic boot(logic [2:0] m);
    ARST_N_I = 1'b0;
    MODE_STRAP_I = m;
    tick(8);
    ARST_N_I = 1'b1;
    tick(2);
    MODE_STRAP_I = ~m;
  endtask
  task automatic acc(logic [15:0] a, logic rw);
    CPU_ADDR_I = a;
    CPU_RW_I = rw;
    CPU_VALID_I = 1'b1;
    tick();
  endtask
  task automatic wr(logic [7:0] d);
    CPU_WDATA_I = d;
    P2_DATA_WR_I = 1'b1;
    tick();
    P2_DATA_WR_I = 1'b0;
    tick();
  endtask
  task automatic epulse();
    E_STB_I = 1'b1;
    tick();
    E_STB_I = 1'b0;
  endtask
  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      boot(3'(m));
      `CHK("mode", 3'(m), MODE_O)
      `CHK("rdback", {3'(m), P2_PIN_I}, P2_DATA_RD_O)
      `CHK("single", m == 4 || m == 7, SINGLE_CHIP_O)
      `CHK("mux", m < 4 || m == 6, MUX_O)
      if (m > 0) `CHK("vecext", m < 4, VEC_EXT_O)
      if (m == 0) begin
        `CHK("dlink", 1'b1, DBUS_LINK_O)
        epulse();
        `CHK("vec0a", 1'b1, VEC_EXT_O)
        epulse();
        `CHK("vec0b", 1'b0, VEC_EXT_O)
      end
    end
  endtask
  task automatic t_m4();
    boot(OMBC_MODE_4);
    acc(16'h3380, 1'b1);
    `CHK("ram80", 1'b1, RAM_SEL_O)
    acc(16'h12FE, 1'b1);
    `CHK("ramfe", 1'b1, RAM_SEL_O)
    acc(16'h337F, 1'b1);
    `CHK("ram7f", 1'b0, RAM_SEL_O)
    acc(16'hFFFE, 1'b1);
    `CHK("rom", 1'b0, ROM_SEL_O)
    wr(8'hDF);
    `CHK("stay4", OMBC_MODE_4, MODE_O)
    wr(8'h20);
    `CHK("to5", OMBC_MODE_5, MODE_O)
    wr(8'h00);
    `CHK("hold5", OMBC_MODE_5, MODE_O)
  endtask
  task automatic t_m5();
    logic [15:0] a[4] = '{16'h00FF, 16'h0100, 16'h01FF, 16'h02A3};
    boot(OMBC_MODE_5);
    `CHK("p4in", 8'hFF, P4_OE_N_O)
    P4_DDR_I = 8'h0F;
    for (int i = 0; i < 4; i++) begin
      acc(a[i], i[0]);
      `CHK("ios", i == 0 || i == 3, STB_A_OUT_O)
      `CHK("rw", i[0], STB_B_OUT_O)
      `CHK("p4oe", 8'hF0, P4_OE_N_O)
      `CHK("p4a", {4'h0, a[i][3:0]}, P4_OUT_O & 8'h0F)
    end
    acc(16'h0006, 1'b1);
    `CHK("ext5", 1'b1, EXT_SEL_O)
    acc(16'h02A3, 1'b1);
    `CHK("ext5no", 1'b0, EXT_SEL_O)
    P4_DDR_I = 8'h00;
  endtask
  task automatic t_mux();
    boot(OMBC_MODE_2);
    acc(16'hA55A, 1'b1);
    `CHK("p4hi", 8'hA5, P4_OUT_O)
    `CHK("p4drv", 8'h00, P4_OE_N_O)
    `CHK("rwm", 1'b1, STB_B_OUT_O)
    `CHK("asidle", 1'b1, STB_A_OUT_O)
    `CHK("p3a", 8'h5A, P3_OUT_O)
    // strobe falls while the low address byte is still driven
    epulse();
    `CHK("asfall", 1'b0, STB_A_OUT_O)
    `CHK("p3adrv", 8'h00, P3_OE_N_O)
    `CHK("p3ahold", 8'h5A, P3_OUT_O)
    epulse();
    `CHK("turn", 8'hFF, P3_OE_N_O)
    epulse();
    `CHK("rdfloat", 8'hFF, P3_OE_N_O)
    `CHK("rdata", 8'h5A, P3_RDATA_O)
    tick();
    `CHK("phases", 1'b1, STB_A_OUT_O)
    acc(16'h0007, 1'b1);
    `CHK("extm", 1'b1, EXT_SEL_O)
  endtask
  task automatic t_m6();
    boot(OMBC_MODE_6);
    `CHK("p6in", 8'hFF, P4_OE_N_O)
    P4_DDR_I = 8'h81;
    tick();
    `CHK("p6dir", 8'h7E, P4_OE_N_O)
    P4_DDR_I = 8'h00;
  endtask
  task automatic t_m7();
    boot(OMBC_MODE_7);
    `CHK("stbaoe", 1'b1, STB_A_OE_N_O)
    P3_IN_STB_I = 1'b0;
    P3_OUT_STB_I = 1'b0;
    tick();
    `CHK("instb", 1'b0, STB_A_IN_O)
    `CHK("outstb", 1'b0, STB_B_OUT_O)
    `CHK("outreq", 1'b1, P3_OUT_STB_O)
    P3_OUT_STB_I = 1'b1;
    tick();
    `CHK("outidle", 1'b1, STB_B_OUT_O)
  endtask
  initial begin
    t_modes();
    t_m4();
    t_m5();
    t_mux();
    t_m6();
    t_m7();
    close_out();
  end
endmodule
